// ### cfi_pkg.sv
/*
 * Shared constants and carrier types for the status-flag and interrupt
 * control block of a small 8-bit core.
 * Assumes one system clock; all register accesses use data-memory addresses.
 */
package cfi_pkg;

   // Data-memory addresses of the two registers.
   localparam logic [6:0] CFI_FLAG_ADDR = 7'h0a;
   localparam logic [6:0] CFI_IRQC_ADDR = 7'h0b;

   // Flag register field positions.
   localparam int CFI_F_CARRY = 0;
   localparam int CFI_F_HALF = 1;
   localparam int CFI_F_ZERO = 2;
   localparam int CFI_F_EXCESS = 3;
   localparam int CFI_F_SLEEP = 4;
   localparam int CFI_F_WDOG = 5;

   // Interrupt control register field positions.
   localparam int CFI_I_GLOBAL = 0;
   localparam int CFI_I_EXT_EN = 1;
   localparam int CFI_I_TMR_EN = 2;
   localparam int CFI_I_CONV_EN = 3;
   localparam int CFI_I_EXT_REQ = 4;
   localparam int CFI_I_TMR_REQ = 5;
   localparam int CFI_I_CONV_REQ = 6;
   localparam int CFI_I_TEST = 7;

   // Reset values.
   localparam logic [7:0] CFI_FLAG_RST = 8'h00;
   localparam logic [7:0] CFI_IRQC_RST = 8'h00;
   localparam logic [3:0] CFI_ARITH_MASK = 4'hf;

   // Interrupt vectors.
   localparam logic [10:0] CFI_VEC_EXT = 11'h004;
   localparam logic [10:0] CFI_VEC_TMR = 11'h008;
   localparam logic [10:0] CFI_VEC_CONV = 11'h00c;

   // Number of interrupt sources.
   localparam int CFI_NSRC = 3;

   // ALU operation class reported by the core.
   typedef enum logic [2:0]
   {
      CFI_ALU_NONE = 3'h0,
      CFI_ALU_ADD = 3'h1,
      CFI_ALU_SUB = 3'h2,
      CFI_ALU_LOGIC = 3'h3,
      CFI_ALU_ROTC = 3'h4
   } cfi_alu_e;

   // Result of one ALU operation, presented for one cycle.
   typedef struct packed
   {
      logic valid;
      cfi_alu_e op;
      logic [7:0] a;
      logic [7:0] b;
      logic carry_in;
      logic [7:0] result;
      logic rot_carry;
   } cfi_alu_s;

   // Register access from the core.
   typedef struct packed
   {
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } cfi_mem_s;

   // Instruction events from the core, each a one-cycle pulse.
   typedef struct packed
   {
      logic halt_op;
      logic watchdog_clear_op;
      logic irq_return_op;
      logic sub_exit_op;
   } cfi_op_s;

   // Request to the sequencer.
   typedef struct packed
   {
      logic take;
      logic [10:0] vector;
   } cfi_call_s;

   // Arbiter state machine.
   typedef enum logic [1:0]
   {
      CFI_ARB_IDLE = 2'b01,
      CFI_ARB_CALL = 2'b10
   } cfi_arb_e;

   // Find the lowest set bit of the ready vector: lower index wins.
   function automatic logic [CFI_NSRC-1:0] cfi_first(
      input logic [CFI_NSRC-1:0] req
   );
      logic [CFI_NSRC-1:0] g;
      logic found;
      g = '0;
      found = 1'b0;
      for (int i = 0; i < CFI_NSRC; i++)
      begin
         if (req[i] && !found)
         begin
            g[i] = 1'b1;
            found = 1'b1;
         end
      end
      return g;
   endfunction

endpackage

// ### cfi_alu_flags.sv
/*
 * Computes the four arithmetic flags from one ALU operation.
 * Assumes the core gives operands, carry-in and result in the same cycle.
 */
`timescale 1ns/1ns
module cfi_alu_flags
   import cfi_pkg::*;
(
   input wire cfi_alu_s alu, // Operation and operands.
   output logic [3:0] flags, // Excess, zero, half, carry.
   output logic [3:0] touch // Which flags this operation updates.
);

   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] bx;
   logic cin;
   logic c7;

   always_comb
   begin
      // Subtraction is addition of the complement; carry then means no borrow.
      bx = (alu.op == CFI_ALU_SUB) ? ~alu.b : alu.b;
      cin = (alu.op == CFI_ALU_SUB) ? 1'b1 : alu.carry_in;
      sum = {1'b0, alu.a} + {1'b0, bx} + {8'h00, cin};
      nib = {1'b0, alu.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
      c7 = alu.a[7] ^ bx[7] ^ sum[7];
      flags = 4'h0;
      touch = 4'h0;
      flags[CFI_F_ZERO] = (alu.result == 8'h00);
      if (alu.valid)
      begin
         unique case (alu.op)
            CFI_ALU_ADD, CFI_ALU_SUB:
            begin
               flags[CFI_F_CARRY] = sum[8];
               flags[CFI_F_HALF] = nib[4];
               flags[CFI_F_EXCESS] = c7 ^ sum[8];
               touch = 4'hf;
            end
            CFI_ALU_LOGIC:
               touch[CFI_F_ZERO] = 1'b1;
            CFI_ALU_ROTC:
            begin
               flags[CFI_F_CARRY] = alu.rot_carry;
               touch[CFI_F_CARRY] = 1'b1;
            end
            default:
               touch = 4'h0;
         endcase
      end
   end

endmodule

// ### cfi_req_latch.sv
/*
 * One sticky interrupt request flag with set-over-clear priority.
 * Assumes the event input is a one-cycle pulse on the system clock.
 */
`timescale 1ns/1ns
module cfi_req_latch
(
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic set_ev, // Request event.
   input wire logic wr_en, // Software write of the flag.
   input wire logic wr_val, // Value written.
   input wire logic clr_ack, // Cleared on service.
   output logic flag // Current request flag.
);

   typedef struct packed
   {
      logic flag;
   } cfi_rl_s;

   cfi_rl_s st_q;
   cfi_rl_s st_d;

   always_comb
   begin
      st_d = st_q;
      if (wr_en)
         st_d.flag = wr_val;
      if (clr_ack)
         st_d.flag = 1'b0;
      // A fresh event must never be lost to a clear in the same cycle.
      if (set_ev)
         st_d.flag = 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         st_q <= '0;
      else if (ce)
         st_q <= st_d;
   end

   assign flag = st_q.flag;

endmodule

// ### cfi_core_ctrl.sv
/*
 * Status flags and interrupt control for a small 8-bit core.
 * Holds the flag register and the interrupt control register, latches
 * the three interrupt requests, arbitrates them and asks the sequencer to
 * push the program counter and branch to a vector.
 * Assumes the sequencer, stack, watchdog and halt timing live elsewhere;
 * the stack full level and the late phase pulse come from the core.
 */
`timescale 1ns/1ns
module cfi_core_ctrl
   import cfi_pkg::*;
(
   input wire logic clk_sys, // System clock, 50 MHz.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic ce, // Clock enable; freezes all state when low.
   input wire cfi_mem_s mem, // Register write from the core.
   input wire logic [6:0] rd_addr, // Register read address.
   output logic [7:0] rd_data, // Read data for rd_addr.
   output logic rd_hit, // High when rd_addr selects a register here.
   input wire cfi_alu_s alu, // ALU operation for flag update.
   input wire cfi_op_s ops, // Instruction event pulses.
   input wire logic wdt_timeout, // Watchdog time-out pulse.
   input wire logic ext_irq_n, // External interrupt pin, active low.
   input wire logic timer_ovf, // Timer overflow pulse.
   input wire logic conv_done, // End of conversion pulse.
   input wire logic late_phase_pulse, // Phase pulse that samples requests.
   input wire logic stack_full, // Return stack holds its last level.
   input wire logic call_done, // Sequencer has taken the call.
   output cfi_call_s call, // Push PC and branch request.
   output logic wake, // Wake request to the halt logic.
   output logic [7:0] flag_reg, // Current flag register contents.
   output logic [7:0] irqc_reg // Current interrupt control register.
);

   typedef struct packed
   {
      logic carry;
      logic half;
      logic zero;
      logic excess;
      logic sleep_flag;
      logic watchdog_expired_flag;
      logic global_irq_enable;
      logic ext_irq_enable;
      logic timer_irq_enable;
      logic conv_irq_enable;
      logic test_bit;
      logic pin_q;
      logic [CFI_NSRC-1:0] ready;
      logic [CFI_NSRC-1:0] grant;
      logic [CFI_NSRC-1:0] halt_req;
      cfi_arb_e arb;
      logic [10:0] vector;
   } cfi_st_s;

   cfi_st_s st_q;
   cfi_st_s st_d;

   logic [3:0] alu_flags;
   logic [3:0] alu_touch;
   logic [CFI_NSRC-1:0] req_flag;
   logic [CFI_NSRC-1:0] req_set;
   logic [CFI_NSRC-1:0] req_en;
   logic [CFI_NSRC-1:0] req_ack;
   logic [CFI_NSRC-1:0] wr_req;
   logic wr_flag;
   logic wr_irqc;
   logic fall_ev;
   logic [CFI_NSRC-1:0] pick;

   cfi_alu_flags u_alu_flags
   (
      .alu(alu),
      .flags(alu_flags),
      .touch(alu_touch)
   );

   assign wr_flag = mem.wr && (mem.addr == CFI_FLAG_ADDR);
   assign wr_irqc = mem.wr && (mem.addr == CFI_IRQC_ADDR);
   // The pin is sampled as a synchronous input; an edge is high then low.
   assign fall_ev = st_q.pin_q && !ext_irq_n;
   assign req_set = {conv_done, timer_ovf, fall_ev};
   assign req_en = {st_q.conv_irq_enable, st_q.timer_irq_enable,
                    st_q.ext_irq_enable};

   generate
      for (genvar i = 0; i < CFI_NSRC; i++)
      begin : g_req
         assign wr_req[i] = wr_irqc;
         cfi_req_latch u_req
         (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .ce(ce),
            .set_ev(req_set[i]),
            .wr_en(wr_req[i]),
            .wr_val(mem.wdata[CFI_I_EXT_REQ + i]),
            .clr_ack(req_ack[i]),
            .flag(req_flag[i])
         );
      end
   endgenerate

   // The served source's flag drops as the call is issued.
   assign req_ack = (st_q.arb == CFI_ARB_IDLE) ? pick : '0;

   always_comb
   begin
      // Service needs global and source enables and a free stack level.
      pick = '0;
      if (late_phase_pulse && st_q.global_irq_enable && !stack_full)
         pick = cfi_first(req_flag & req_en);
   end

   always_comb
   begin
      st_d = st_q;
      st_d.pin_q = ext_irq_n;

      if (alu.valid)
      begin
         if (alu_touch[CFI_F_CARRY])
            st_d.carry = alu_flags[CFI_F_CARRY];
         if (alu_touch[CFI_F_HALF])
            st_d.half = alu_flags[CFI_F_HALF];
         if (alu_touch[CFI_F_ZERO])
            st_d.zero = alu_flags[CFI_F_ZERO];
         if (alu_touch[CFI_F_EXCESS])
            st_d.excess = alu_flags[CFI_F_EXCESS];
      end

      // A data write beats the ALU update; sleep and watchdog stay put.
      if (wr_flag)
      begin
         st_d.carry = mem.wdata[CFI_F_CARRY];
         st_d.half = mem.wdata[CFI_F_HALF];
         st_d.zero = mem.wdata[CFI_F_ZERO];
         st_d.excess = mem.wdata[CFI_F_EXCESS];
      end

      if (ops.watchdog_clear_op)
      begin
         st_d.sleep_flag = 1'b0;
         st_d.watchdog_expired_flag = 1'b0;
      end
      if (ops.halt_op)
      begin
         st_d.sleep_flag = 1'b1;
         st_d.watchdog_expired_flag = 1'b0;
         // Flags already pending at halt do not wake the core.
         st_d.halt_req = req_flag;
      end
      if (wdt_timeout)
         st_d.watchdog_expired_flag = 1'b1;

      if (wr_irqc)
      begin
         st_d.global_irq_enable = mem.wdata[CFI_I_GLOBAL];
         st_d.ext_irq_enable = mem.wdata[CFI_I_EXT_EN];
         st_d.timer_irq_enable = mem.wdata[CFI_I_TMR_EN];
         st_d.conv_irq_enable = mem.wdata[CFI_I_CONV_EN];
         st_d.test_bit = mem.wdata[CFI_I_TEST];
      end
      if (ops.irq_return_op)
         st_d.global_irq_enable = 1'b1;

      st_d.ready = req_flag & req_en;

      unique case (st_q.arb)
         CFI_ARB_IDLE:
         begin
            if (|pick)
            begin
               // Only the PC is pushed; the flags are never stacked.
               st_d.global_irq_enable = 1'b0;
               st_d.grant = pick;
               st_d.arb = CFI_ARB_CALL;
               st_d.vector = pick[0] ? CFI_VEC_EXT :
                             pick[1] ? CFI_VEC_TMR :
                             CFI_VEC_CONV;
            end
         end
         CFI_ARB_CALL:
         begin
            if (call_done)
            begin
               st_d.arb = CFI_ARB_IDLE;
               st_d.grant = '0;
            end
         end
         default:
            st_d.arb = CFI_ARB_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         st_q <= '0;
         st_q.pin_q <= 1'b1;
         st_q.arb <= CFI_ARB_IDLE;
         st_q.vector <= CFI_VEC_EXT;
      end
      else if (ce)
         st_q <= st_d;
   end

   always_comb
   begin
      flag_reg = CFI_FLAG_RST;
      flag_reg[CFI_F_CARRY] = st_q.carry;
      flag_reg[CFI_F_HALF] = st_q.half;
      flag_reg[CFI_F_ZERO] = st_q.zero;
      flag_reg[CFI_F_EXCESS] = st_q.excess;
      flag_reg[CFI_F_SLEEP] = st_q.sleep_flag;
      flag_reg[CFI_F_WDOG] = st_q.watchdog_expired_flag;
      irqc_reg = CFI_IRQC_RST;
      irqc_reg[CFI_I_GLOBAL] = st_q.global_irq_enable;
      irqc_reg[CFI_I_EXT_EN] = st_q.ext_irq_enable;
      irqc_reg[CFI_I_TMR_EN] = st_q.timer_irq_enable;
      irqc_reg[CFI_I_CONV_EN] = st_q.conv_irq_enable;
      irqc_reg[CFI_I_EXT_REQ] = req_flag[0];
      irqc_reg[CFI_I_TMR_REQ] = req_flag[1];
      irqc_reg[CFI_I_CONV_REQ] = req_flag[2];
      irqc_reg[CFI_I_TEST] = st_q.test_bit;
   end

   always_comb
   begin
      rd_hit = 1'b1;
      if (rd_addr == CFI_FLAG_ADDR)
         rd_data = flag_reg;
      else if (rd_addr == CFI_IRQC_ADDR)
         rd_data = irqc_reg;
      else
      begin
         rd_data = 8'h00;
         rd_hit = 1'b0;
      end
   end

   assign call.take = (st_q.arb == CFI_ARB_CALL);
   assign call.vector = st_q.vector;
   // Wake on a request flag that was not already pending at halt.
   assign wake = st_q.sleep_flag && |(req_flag & ~st_q.halt_req);

endmodule

// ### cfi_core_ctrl_checker.sv
/*
 * Port assertions for the flag and interrupt control block.
 * Assumes it is bound to the block's top module; checks pause while the
 * clock enable is low, since state is frozen then.
 */
`timescale 1ns/1ns
module cfi_core_ctrl_checker
   import cfi_pkg::*;
(
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic ce, // Clock enable.
   input wire cfi_mem_s mem, // Register write.
   input wire cfi_op_s ops, // Instruction pulses.
   input wire logic wdt_timeout, // Watchdog time-out.
   input wire logic ext_irq_n, // External pin.
   input wire logic timer_ovf, // Timer event.
   input wire logic conv_done, // Converter event.
   input wire logic late_phase_pulse, // Sampling pulse.
   input wire logic stack_full, // Stack full level.
   input wire logic call_done, // Call accepted.
   input wire cfi_call_s call, // Call request.
   input wire logic [7:0] flag_reg, // Flag register.
   input wire logic [7:0] irqc_reg // Control register.
);
   logic [2:0] rdy;
   logic [10:0] exp_vec;
   assign rdy = irqc_reg[3:1] & irqc_reg[6:4];
   assign exp_vec = rdy[0] ? 11'h004 : (rdy[1] ? 11'h008 : 11'h00c);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n || !ce);
   sequence s_pick;
      late_phase_pulse && irqc_reg[0] && !stack_full && !call.take
         && rdy != 3'h0;
   endsequence
   sequence s_served;
      call.take && !irqc_reg[0] && call.vector == $past(exp_vec);
   endsequence
   a_pick_vector:
      assert property (s_pick |=> s_served)
      else $error("call request or vector wrong");
   a_full_hold:
      assert property (stack_full && !call.take |=> !call.take)
      else $error("call raised while stack full");
   a_gie_mask:
      assert property (!irqc_reg[0] && !call.take |=> !call.take)
      else $error("call raised with global enable clear");
   a_phase_only:
      assert property (!late_phase_pulse && !call.take |=> !call.take)
      else $error("call raised outside the phase pulse");
   a_take_stand:
      assert property (call.take && !call_done |=> call.take
         && $stable(call.vector))
      else $error("call request dropped early");
   a_take_drop:
      assert property (call.take && call_done |=> !call.take)
      else $error("call request held after acceptance");
   a_ext_latch:
      assert property ($fell(ext_irq_n) |=> irqc_reg[4])
      else $error("external request not latched");
   a_tmr_latch:
      assert property (timer_ovf |=> irqc_reg[5])
      else $error("timer request not latched");
   a_conv_latch:
      assert property (conv_done |=> irqc_reg[6])
      else $error("converter request not latched");
   a_irq_return_op_gie:
      assert property (ops.irq_return_op && !late_phase_pulse
         |=> irqc_reg[0])
      else $error("interrupt return left global enable clear");
   a_halt_flags:
      assert property (ops.halt_op && !wdt_timeout
         |=> flag_reg[5:4] == 2'b01)
      else $error("halt flags wrong");
   a_wdog_set:
      assert property (wdt_timeout |=> flag_reg[5])
      else $error("watchdog flag not set");
   a_top_zero:
      assert property (flag_reg[7:6] == 2'b00)
      else $error("unused flag bits not zero");
   a_flag_write:
      assert property (mem.wr && mem.addr == 7'h0a && ops == '0
         && !wdt_timeout |=> flag_reg[3:0] == $past(mem.wdata[3:0])
         && $stable(flag_reg[5:4]))
      else $error("flag register write wrong");
endmodule

// ### cfi_far_model.sv
/*
 * Sequencer and return stack on the far side of the interrupt block.
 * Answers each call after a short or long wait and tracks stack depth.
 */
`timescale 1ns/1ns
module cfi_far_model
#(
   parameter int DEPTH = 6
)
(
   input wire logic clk_sys, // System clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic take, // Call request from the block.
   input wire logic push, // Plain subroutine call.
   input wire logic pop, // Any return.
   input wire logic slow, // Long answer wait.
   output logic call_done, // Call accepted pulse.
   output logic stack_full // Stack at its last level.
);
   typedef struct packed
   {
      logic done;
      logic [2:0] wt;
      logic [2:0] lvl;
   } cfi_far_s;
   cfi_far_s s_q;
   cfi_far_s s_d;
   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (take && !s_q.done)
      begin
         s_d.wt = s_q.wt + 3'h1;
         if (s_q.wt >= (slow ? 3'h5 : 3'h0))
         begin
            s_d.done = 1'b1;
            s_d.wt = 3'h0;
         end
      end
      // Only the return address is stacked, so depth is all we keep.
      if ((push || s_d.done) && s_q.lvl < 3'(DEPTH))
         s_d.lvl = s_q.lvl + 3'h1;
      else if (pop && s_q.lvl != 3'h0)
         s_d.lvl = s_q.lvl - 3'h1;
   end
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
   assign call_done = s_q.done;
   assign stack_full = s_q.lvl == 3'(DEPTH);
endmodule

// ### tb_cfi_core_ctrl.sv
/*
 * Self-checking bench for the flag and interrupt control block.
 * Assumes the far model answers calls and keeps the stack depth.
 */
`timescale 1ns/1ns
module tb_cfi_core_ctrl;
   import cfi_pkg::*;
   logic clk_sys, rst_n, ce, wdt_timeout, ext_irq_n, timer_ovf, conv_done;
   logic late_phase_pulse, stack_full, call_done, wake, rd_hit, push, slow;
   logic pop;
   logic [1:0] ph;
   logic [6:0] rd_addr;
   logic [7:0] rd_data, flag_reg, irqc_reg;
   cfi_mem_s mem;
   cfi_alu_s alu;
   cfi_op_s ops;
   cfi_call_s call;
   int err_count, n_tests, i;
   assign pop = ops.irq_return_op | ops.sub_exit_op;
   cfi_core_ctrl i_cfi_core_ctrl (.clk_sys, .rst_n, .ce, .mem, .rd_addr,
      .rd_data, .rd_hit, .alu, .ops, .wdt_timeout, .ext_irq_n, .timer_ovf,
      .conv_done, .late_phase_pulse, .stack_full, .call_done, .call, .wake,
      .flag_reg, .irqc_reg);
   cfi_far_model i_cfi_far_model (.clk_sys, .rst_n, .take(call.take),
      .push, .pop, .slow, .call_done, .stack_full);
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // The sampling pulse comes every fourth cycle, like an instruction phase.
   always @(posedge clk_sys)
   begin
      ph <= ph + 2'h1;
      late_phase_pulse <= (ph == 2'h2);
   end
   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [10:0] exp, got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      mem <= '{1'b1, a, d};
      @(posedge clk_sys);
      mem.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic h,
      input logic [7:0] d);
      @(posedge clk_sys);
      rd_addr <= a;
      #1;
      chk("rd_hit", h, rd_hit);
      if (h)
         chk("rd_data", d, rd_data);
   endtask
   // Event mask bits: watchdog, timer, converter, plain call, pin fall.
   task automatic ev(input cfi_op_s o, input logic [4:0] m);
      @(posedge clk_sys);
      ops <= o;
      {wdt_timeout, timer_ovf, conv_done, push} <= m[4:1];
      ext_irq_n <= !m[0];
      @(posedge clk_sys);
      ops <= '0;
      {wdt_timeout, timer_ovf, conv_done, push} <= 4'h0;
      ext_irq_n <= 1'b1;
      tick(1);
   endtask
   task automatic al(input cfi_alu_e op, input logic [7:0] a, b, r,
      input logic rc, input logic [7:0] ef);
      @(posedge clk_sys);
      alu <= '{1'b1, op, a, b, 1'b0, r, rc};
      @(posedge clk_sys);
      alu.valid <= 1'b0;
      #1;
      chk("flag_reg", ef, flag_reg);
   endtask
   task automatic wait_take(input logic lvl);
      int n;
      n = 0;
      while (call.take !== lvl)
      begin
         tick(1);
         n++;
         if (n > 40)
         begin
            chk("call.take", lvl, call.take);
            end_of_test();
         end
      end
   endtask
   task automatic serve(input logic [10:0] v, input logic [7:0] ic);
      wait_take(1'b1);
      chk("call.vector", v, call.vector);
      chk("irqc_reg", ic, irqc_reg);
      wait_take(1'b0);
   endtask
   initial
   begin
      {rst_n, wdt_timeout, timer_ovf, conv_done, push, slow} = 6'h00;
      {ce, ext_irq_n, ph, late_phase_pulse} = 5'h18;
      {mem, alu, ops, rd_addr} = '0;
      {err_count, n_tests} = 64'h0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      tick(1);
      chk("flag_reg", 8'h00, flag_reg);
      chk("irqc_reg", 8'h00, irqc_reg);
      rd(7'h0a, 1'b1, 8'h00);
      rd(7'h0b, 1'b1, 8'h00);
      rd(7'h0c, 1'b0, 8'h00);
      wr(7'h0a, 8'hff);
      chk("flag_reg", 8'h0f, flag_reg);
      rd(7'h0a, 1'b1, 8'h0f);
      al(CFI_ALU_ADD, 8'h0f, 8'h01, 8'h10, 1'b0, 8'h02);
      al(CFI_ALU_ADD, 8'h80, 8'h80, 8'h00, 1'b0, 8'h0d);
      al(CFI_ALU_SUB, 8'h05, 8'h05, 8'h00, 1'b0, 8'h07);
      al(CFI_ALU_LOGIC, 8'h01, 8'h01, 8'h01, 1'b0, 8'h03);
      al(CFI_ALU_ROTC, 8'h20, 8'h00, 8'h40, 1'b0, 8'h02);
      ev(4'h8, 5'h00);
      chk("flag_reg", 8'h12, flag_reg);
      ev(4'h0, 5'h10);
      chk("flag_reg", 8'h32, flag_reg);
      wr(7'h0a, 8'h00);
      chk("flag_reg", 8'h30, flag_reg);
      ev(4'h8, 5'h00);
      chk("flag_reg", 8'h10, flag_reg);
      ev(4'h0, 5'h08);
      chk("wake", 1'b1, wake);
      chk("irqc_reg", 8'h20, irqc_reg);
      ev(4'h4, 5'h00);
      chk("flag_reg", 8'h00, flag_reg);
      wr(7'h0b, 8'h0e);
      ev(4'h0, 5'h0d);
      tick(2);
      chk("irqc_reg", 8'h7e, irqc_reg);
      wr(7'h0b, 8'h7f);
      serve(11'h004, 8'h6e);
      wr(7'h0b, 8'h6f);
      serve(11'h008, 8'h4e);
      ev(4'h2, 5'h00);
      serve(11'h00c, 8'h0e);
      ev(4'h1, 5'h00);
      chk("irqc_reg", 8'h0e, irqc_reg);
      // A slow sequencer answer tests that the call request stands.
      slow <= 1'b1;
      for (i = 0; i < 8 && stack_full !== 1'b1; i++)
         ev(4'h0, 5'h02);
      chk("stack_full", 1'b1, stack_full);
      wr(7'h0b, 8'h05);
      ev(4'h0, 5'h08);
      tick(12);
      chk("call.take", 1'b0, call.take);
      chk("irqc_reg", 8'h25, irqc_reg);
      ev(4'h1, 5'h00);
      serve(11'h008, 8'h04);
      // With the clock enable low a timer event must leave no trace.
      ce <= 1'b0;
      ev(4'h0, 5'h08);
      ce <= 1'b1;
      tick(1);
      chk("irqc_reg", 8'h04, irqc_reg);
      end_of_test();
   end
endmodule
bind cfi_core_ctrl cfi_core_ctrl_checker i_cfi_core_ctrl_checker (
   .clk_sys, .rst_n, .ce, .mem, .ops, .wdt_timeout, .ext_irq_n, .timer_ovf,
   .conv_done, .late_phase_pulse, .stack_full, .call_done, .call,
   .flag_reg, .irqc_reg);
